// File: src/rsc_regulators.sv
// two-regulator sequencing control: registers, slot sequencer, faults, irq
// assumes fault and low-power pins are asynchronous, one 200 MHz clock
// What this block does
// R1 - fault raises irq if enabled, then acts per action field
// R2 - action code 11 behaves as system shutdown
// R3 - startup slot 0000 keeps regulator off
// R4 - codes 1..14 enable in that startup slot
// R5 - startup code 1111 enables on entering active
// R6 - shutdown code 0000/1111 disables on entering off
// R7 - codes 1..14 disable in that shutdown slot
// R8 - sleep 00 uses image voltage, 01 disables
// R9 - software avoids reserved sleep codes 10, 11
// R10 - sleep trigger selects register bit or inputs
// R11 - five-bit code decodes 50mV then 100mV steps
// R12 - normal code applies only in regulator mode
// R13 - switch bit runs current-limited, ignores code
// R14 - float bit zero discharges disabled output
// R15 - all four disabled forces every discharge
// R16 - state machine reset restores mask defaults
// R17 - step slots upward, switching assigned regulators
module rsc_regulators
    import rsc_pkg::*;
#(
    parameter logic [15:0] DEF_ONE_SEQ  = RST_ONE_SEQ,
    parameter logic [15:0] DEF_ONE_LP   = RST_ONE_LP,
    parameter logic [15:0] DEF_TWO_CTRL = RST_TWO_CTRL,
    parameter logic [15:0] DEF_TWO_SEQ  = RST_TWO_SEQ,
    parameter int          SLOT_LEN     = SLOT_CYCLES
) (
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        sm_reset,
    input  wire logic [7:0]  addr,
    input  wire logic [15:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [15:0] rdata,
    input  wire logic        fault_one,
    input  wire logic        fault_two,
    input  wire logic        low_power_input_one,
    input  wire logic        low_power_input_two,
    input  wire logic        low_power_input_three,
    input  wire logic        sleep_reg_bit,
    input  wire logic        others_disabled,
    input  wire logic [4:0]  reg_one_normal_code,
    input  wire logic        reg_one_switch_mode,
    input  wire logic        reg_one_output_float,
    output logic             reg_one_enable,
    output logic             reg_two_enable,
    output logic      [11:0] reg_one_target_mv,
    output logic      [11:0] reg_two_target_mv,
    output logic             reg_two_switch_out,
    output logic             reg_one_discharge,
    output logic             reg_two_discharge,
    output logic             system_shutdown,
    output logic             irq
);
    localparam int SC_W = $clog2(SLOT_LEN + 1);

    // voltage code to millivolts: 50mV steps then 100mV steps
    function automatic logic [11:0] code_to_mv(input logic [4:0] c);
        if (c[4])
            code_to_mv = 12'd1800 + 12'(c[3:0]) * 12'd100; // R11
        else
            code_to_mv = 12'd900 + 12'(c[3:0]) * 12'd50;   // R11
    endfunction : code_to_mv

    logic [15:0]     reg_one_seq, reg_one_lp, reg_two_ctrl, reg_two_seq;
    logic [1:0]      irq_status, irq_enable;
    logic            up_req, down_req, sleep_sel;
    rsc_state_t      state;
    logic [3:0]      slot;
    logic [SC_W-1:0] slot_cnt;
    logic [4:0]      pin_meta, pin_sync, pin_prev;
    logic            reg_one_on, reg_two_on, one_tripped, two_tripped;
    logic            clr_wr, any_reset;

    assign any_reset = rst | sm_reset;
    assign clr_wr = wr && addr == ADDR_IRQ_CLEAR;

    // two-flop synchronisers for faults and low-power pins
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pin_meta <= 5'h00;
            pin_sync <= 5'h00;
            pin_prev <= 5'h00;
        end else begin
            pin_meta <= {low_power_input_three, low_power_input_two,
                         low_power_input_one, fault_two, fault_one};
            pin_sync <= pin_meta;
            pin_prev <= pin_sync;
        end
    end

    wire [1:0] fault_rise = pin_sync[1:0] & ~pin_prev[1:0];
    wire [1:0] act_one = reg_one_seq[FAULT_ACT_LSB +: 2];
    wire [1:0] act_two = reg_two_seq[FAULT_ACT_LSB +: 2];

    // control fields, reset by bus reset or power state machine
    always_ff @(posedge core_clk) begin
        if (any_reset) begin
            reg_one_seq  <= DEF_ONE_SEQ;   // R16
            reg_one_lp   <= DEF_ONE_LP;    // R16
            reg_two_ctrl <= DEF_TWO_CTRL;  // R16
            reg_two_seq  <= DEF_TWO_SEQ;   // R16
        end else if (wr) begin
            if (addr == ADDR_ONE_SEQ)  reg_one_seq  <= wdata & MASK_SEQ;
            if (addr == ADDR_ONE_LP)   reg_one_lp   <= wdata & MASK_LP;
            if (addr == ADDR_TWO_CTRL) reg_two_ctrl <= wdata & MASK_CTRL;
            if (addr == ADDR_TWO_SEQ)  reg_two_seq  <= wdata & MASK_SEQ;
        end
    end

    // sticky fault status, set wins over clear
    always_ff @(posedge core_clk) begin
        if (rst) begin
            irq_status <= 2'h0;
            irq_enable <= 2'h0;
        end else begin
            irq_status <= (irq_status & ~(clr_wr ? wdata[1:0] : 2'h0)) | fault_rise; // R1
            if (wr && addr == ADDR_IRQ_ENABLE) irq_enable <= wdata[1:0];
        end
    end
    assign irq = |(irq_status & irq_enable); // R1

    // power-up and power-down requests, one-cycle pulses
    always_ff @(posedge core_clk) begin
        if (rst) begin
            up_req   <= 1'b0;
            down_req <= 1'b0;
        end else begin
            up_req   <= wr && addr == ADDR_SEQ_CMD && wdata[0];
            down_req <= wr && addr == ADDR_SEQ_CMD && wdata[1];
        end
    end

    // system shutdown on fault with action 10 or reserved 11
    wire sys_fault = (fault_rise[0] && act_one[1]) || (fault_rise[1] && act_two[1]); // R1 R2

    // slot sequencer
    wire slot_done = slot_cnt == SC_W'(SLOT_LEN - 1);
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state    <= RSC_OFF;
            slot     <= 4'h0;
            slot_cnt <= '0;
        end else begin
            unique case (state)
                RSC_OFF: begin
                    if (up_req) begin
                        state    <= RSC_STARTUP;
                        slot     <= 4'h1;
                        slot_cnt <= '0;
                    end
                end
                RSC_STARTUP: begin
                    if (sys_fault || down_req) begin
                        state    <= RSC_SHUTDOWN;
                        slot     <= 4'h1;
                        slot_cnt <= '0;
                    end else if (slot_done) begin
                        slot_cnt <= '0;
                        if (slot == SLOT_LAST) state <= RSC_ACTIVE; // R17
                        else slot <= slot + 4'h1;                   // R17
                    end else begin
                        slot_cnt <= slot_cnt + SC_W'(1);
                    end
                end
                RSC_ACTIVE: begin
                    if (sys_fault || down_req) begin
                        state    <= RSC_SHUTDOWN;
                        slot     <= 4'h1;
                        slot_cnt <= '0;
                    end
                end
                RSC_SHUTDOWN: begin
                    if (slot_done) begin
                        slot_cnt <= '0;
                        if (slot == SLOT_LAST) state <= RSC_OFF; // R17
                        else slot <= slot + 4'h1;                // R17
                    end else begin
                        slot_cnt <= slot_cnt + SC_W'(1);
                    end
                end
                default: state <= RSC_OFF;
            endcase
        end
    end

    // enable decision for one regulator from its sequencing register
    function automatic logic next_on(input logic cur, input logic [15:0] sq,
                                     input rsc_state_t st, input logic [3:0] sl,
                                     input logic sd);
        logic [3:0] up_s, dn_s;
        up_s = sq[START_SLOT_LSB +: 4];
        dn_s = sq[STOP_SLOT_LSB +: 4];
        next_on = cur;
        if (st == RSC_STARTUP && sd && up_s != SLOT_NONE && up_s == sl)
            next_on = 1'b1;                                  // R3 R4
        if (st == RSC_STARTUP && sd && sl == SLOT_LAST && up_s == SLOT_ACTIVE)
            next_on = 1'b1;                                  // R5
        if (st == RSC_SHUTDOWN && sd && dn_s == sl && dn_s != SLOT_ACTIVE)
            next_on = 1'b0;                                  // R7
        if (st == RSC_SHUTDOWN && sd && sl == SLOT_LAST &&
            (dn_s == SLOT_NONE || dn_s == SLOT_ACTIVE))
            next_on = 1'b0;                                  // R6
    endfunction : next_on

    // regulator enables, fault trips switch a single regulator off
    always_ff @(posedge core_clk) begin
        if (rst) begin
            reg_one_on  <= 1'b0;
            reg_two_on  <= 1'b0;
            one_tripped <= 1'b0;
            two_tripped <= 1'b0;
        end else begin
            reg_one_on <= next_on(reg_one_on, reg_one_seq, state, slot, slot_done);
            reg_two_on <= next_on(reg_two_on, reg_two_seq, state, slot, slot_done);
            if (fault_rise[0] && act_one == ACT_REG_OFF) one_tripped <= 1'b1; // R1
            else if (state == RSC_OFF) one_tripped <= 1'b0;
            if (fault_rise[1] && act_two == ACT_REG_OFF) two_tripped <= 1'b1; // R1
            else if (state == RSC_OFF) two_tripped <= 1'b0;
        end
    end

    // hibernate trigger select
    always_comb begin
        unique case (reg_one_lp[SLEEP_TRIG_LSB +: 2])        // R10
            2'h0:    sleep_sel = sleep_reg_bit;
            2'h1:    sleep_sel = pin_sync[2];
            2'h2:    sleep_sel = pin_sync[3];
            default: sleep_sel = pin_sync[4];
        endcase
    end

    wire sleep_beh = reg_one_lp[SLEEP_BEH_LSB];              // R8
    wire one_en = reg_one_on && !one_tripped && !(sleep_sel && sleep_beh); // R8
    wire two_en = reg_two_on && !two_tripped;
    wire all_off = !one_en && !two_en && others_disabled;    // R15

    // registered outputs to the analog regulators
    always_ff @(posedge core_clk) begin
        if (rst) begin
            reg_one_enable     <= 1'b0;
            reg_two_enable     <= 1'b0;
            reg_one_target_mv  <= 12'h000;
            reg_two_target_mv  <= 12'h000;
            reg_two_switch_out <= 1'b0;
            reg_one_discharge  <= 1'b1;
            reg_two_discharge  <= 1'b1;
            system_shutdown    <= 1'b0;
        end else begin
            reg_one_enable <= one_en;
            reg_two_enable <= two_en;
            if (reg_one_switch_mode)
                reg_one_target_mv <= 12'h000;                // R13
            else if (sleep_sel && !sleep_beh)
                reg_one_target_mv <= code_to_mv(reg_one_lp[VCODE_LSB +: 5]); // R8 R11
            else
                reg_one_target_mv <= code_to_mv(reg_one_normal_code);
            reg_two_switch_out <= reg_two_ctrl[SWITCH_BIT];  // R13
            reg_two_target_mv  <= reg_two_ctrl[SWITCH_BIT] ? 12'h000
                                : code_to_mv(reg_two_ctrl[VCODE_LSB +: 5]); // R12
            reg_one_discharge <= !one_en && (!reg_one_output_float || all_off); // R14 R15
            reg_two_discharge <= !two_en && (!reg_two_ctrl[FLOAT_BIT] || all_off); // R14 R15
            system_shutdown   <= sys_fault;                  // R2
        end
    end

    // read data one cycle after the strobe, unmapped reads zero
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rdata <= 16'h0000;
        end else if (rd) begin
            unique case (addr)
                ADDR_ONE_SEQ:    rdata <= reg_one_seq;
                ADDR_ONE_LP:     rdata <= reg_one_lp;
                ADDR_TWO_CTRL:   rdata <= reg_two_ctrl;
                ADDR_TWO_SEQ:    rdata <= reg_two_seq;
                ADDR_IRQ_STATUS: rdata <= {14'h0000, irq_status};
                ADDR_IRQ_ENABLE: rdata <= {14'h0000, irq_enable};
                ADDR_SEQ_STATUS: rdata <= {7'h00, reg_two_on, reg_one_on,
                                           state, slot};
                default:         rdata <= 16'h0000;
            endcase
        end else begin
            rdata <= 16'h0000;
        end
    end

    property p_fault_irq;
        @(posedge core_clk) disable iff (rst)
        fault_rise[0] && irq_enable[0] && !clr_wr |=> irq;
    endproperty
    a_fault_irq: assert property (p_fault_irq) else $error("fault did not raise irq"); // R1

    property p_sys_down;
        @(posedge core_clk) disable iff (rst)
        fault_rise[1] && act_two[1] |=> system_shutdown;
    endproperty
    a_sys_down: assert property (p_sys_down) else $error("no system shutdown"); // R2

    property p_slot_zero;
        @(posedge core_clk) disable iff (rst)
        state == RSC_STARTUP && reg_one_seq[START_SLOT_LSB +: 4] == SLOT_NONE
            && !reg_one_on |=> !reg_one_on;
    endproperty
    a_slot_zero: assert property (p_slot_zero) else $error("slot zero enabled"); // R3

    property p_slot_on;
        @(posedge core_clk) disable iff (rst || sm_reset)
        state == RSC_STARTUP && slot_done && reg_two_seq[START_SLOT_LSB +: 4] == slot
            && slot != SLOT_NONE && !sys_fault |=> reg_two_on ##1 reg_two_enable || two_tripped;
    endproperty
    a_slot_on: assert property (p_slot_on) else $error("slot start missed"); // R4

    property p_off_entry;
        @(posedge core_clk) disable iff (rst)
        state == RSC_OFF && $past(state) == RSC_SHUTDOWN
            |-> !reg_one_on && !reg_two_on;
    endproperty
    a_off_entry: assert property (p_off_entry) else $error("regulator left on in off"); // R6 R7

    property p_switch;
        @(posedge core_clk) disable iff (rst)
        reg_two_ctrl[SWITCH_BIT] |=> reg_two_target_mv == 12'h000;
    endproperty
    a_switch: assert property (p_switch) else $error("voltage used in switch mode"); // R13

    property p_code;
        @(posedge core_clk) disable iff (rst)
        !reg_two_ctrl[SWITCH_BIT] && reg_two_ctrl[4:0] == 5'h1F |=> reg_two_target_mv == 12'd3300;
    endproperty
    a_code: assert property (p_code) else $error("bad voltage decode"); // R11 R12

    property p_float;
        @(posedge core_clk) disable iff (rst)
        !two_en && !reg_two_ctrl[FLOAT_BIT] |=> reg_two_discharge;
    endproperty
    a_float: assert property (p_float) else $error("no discharge"); // R14

    property p_all_off;
        @(posedge core_clk) disable iff (rst)
        all_off |=> reg_one_discharge && reg_two_discharge;
    endproperty
    a_all_off: assert property (p_all_off) else $error("all off not discharged"); // R15

    property p_smreset;
        @(posedge core_clk) disable iff (rst)
        sm_reset |=> reg_two_seq == DEF_TWO_SEQ;
    endproperty
    a_smreset: assert property (p_smreset) else $error("defaults not restored"); // R16

    c_active:   cover property (@(posedge core_clk) state == RSC_ACTIVE);
    c_shutdown: cover property (@(posedge core_clk) state == RSC_SHUTDOWN && slot == SLOT_LAST);
    c_irq:      cover property (@(posedge core_clk) irq);
    c_sysdown:  cover property (@(posedge core_clk) system_shutdown);
endmodule : rsc_regulators

// File: src/rsc_pkg.sv
// package for the two-regulator sequencing control block
// assumes one clock domain, plain register port with 8-bit addresses
package rsc_pkg;
    // register offsets (byte-wide index space of the control interface)
    localparam logic [7:0]  ADDR_ONE_SEQ     = 8'hC9;
    localparam logic [7:0]  ADDR_ONE_LP      = 8'hCA;
    localparam logic [7:0]  ADDR_TWO_CTRL    = 8'hCB;
    localparam logic [7:0]  ADDR_TWO_SEQ     = 8'hCC;
    localparam logic [7:0]  ADDR_IRQ_STATUS  = 8'hD0;
    localparam logic [7:0]  ADDR_IRQ_CLEAR   = 8'hD1;
    localparam logic [7:0]  ADDR_IRQ_ENABLE  = 8'hD2;
    localparam logic [7:0]  ADDR_SEQ_CMD     = 8'hD3;
    localparam logic [7:0]  ADDR_SEQ_STATUS  = 8'hD4;
    // field positions
    localparam int FAULT_ACT_LSB  = 14;
    localparam int START_SLOT_LSB = 10;
    localparam int STOP_SLOT_LSB  = 6;
    localparam int SLEEP_BEH_LSB  = 12;
    localparam int SLEEP_TRIG_LSB = 8;
    localparam int VCODE_LSB      = 0;
    localparam int SWITCH_BIT     = 14;
    localparam int FLOAT_BIT      = 10;
    // writable bit masks per register
    localparam logic [15:0] MASK_SEQ  = 16'hFFC0;
    localparam logic [15:0] MASK_LP   = 16'h331F;
    localparam logic [15:0] MASK_CTRL = 16'h441F;
    // mask-programmed defaults, overridable at top level
    localparam logic [15:0] RST_ONE_SEQ  = 16'h0C00;
    localparam logic [15:0] RST_ONE_LP   = 16'h001C;
    localparam logic [15:0] RST_TWO_CTRL = 16'h001B;
    localparam logic [15:0] RST_TWO_SEQ  = 16'h0800;
    // slot codes and fault actions
    localparam logic [3:0] SLOT_NONE   = 4'h0;
    localparam logic [3:0] SLOT_ACTIVE = 4'hF;
    localparam logic [3:0] SLOT_LAST   = 4'hE;
    localparam logic [1:0] ACT_IGNORE  = 2'h0;
    localparam logic [1:0] ACT_REG_OFF = 2'h1;
    // time per sequencing slot
    localparam int SLOT_TIME_NS   = 2000;
    localparam int CLK_PERIOD_NS  = 5;
    localparam int SLOT_CYCLES    = SLOT_TIME_NS / CLK_PERIOD_NS;
    typedef enum logic [2:0] {
        RSC_OFF      = 3'b000,
        RSC_STARTUP  = 3'b001,
        RSC_ACTIVE   = 3'b010,
        RSC_SHUTDOWN = 3'b011
    } rsc_state_t;
endpackage : rsc_pkg

// File: tb/rsc_regulators_bench.sv
// self-checking bench for the two-regulator sequencing control block
// assumes the block's own assertions run inside it; shortened slot length
module rsc_regulators_bench
    import rsc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    `define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin miscompares++; \
        $display("[ERR] %0t got %h exp %h", $time, (got), (exp)); end end
    localparam int SLOT_SIM = 4;
    logic        core_clk = 1'b0, rst = 1'b1, sm_reset = 1'b0, wr = 1'b0, rd = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [15:0] wdata = 16'h0000;
    logic [15:0] rdata, rv;
    logic        fault_one = 1'b0, fault_two = 1'b0, sleep_reg_bit = 1'b0;
    logic        low_power_input_one = 1'b0, low_power_input_two = 1'b0;
    logic        low_power_input_three = 1'b0, others_disabled = 1'b0;
    logic [4:0]  reg_one_normal_code = 5'h05;
    logic        reg_one_switch_mode = 1'b0, reg_one_output_float = 1'b0;
    logic        reg_one_enable, reg_two_enable, reg_two_switch_out, irq, system_shutdown;
    logic        reg_one_discharge, reg_two_discharge, saw;
    logic [11:0] reg_one_target_mv, reg_two_target_mv;
    int          miscompares = 0, n_checks = 0, t1, t2;
    logic [4:0]  codes [5] = '{5'h00, 5'h0F, 5'h10, 5'h1F, 5'h0A};

    // clock at 200 MHz
    always #2.5 core_clk = ~core_clk;

    rsc_regulators #(.SLOT_LEN(SLOT_SIM)) i_dut (
        .core_clk(core_clk), .rst(rst), .sm_reset(sm_reset), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .fault_one(fault_one),
        .fault_two(fault_two), .low_power_input_one(low_power_input_one),
        .low_power_input_two(low_power_input_two),
        .low_power_input_three(low_power_input_three), .sleep_reg_bit(sleep_reg_bit),
        .others_disabled(others_disabled), .reg_one_normal_code(reg_one_normal_code),
        .reg_one_switch_mode(reg_one_switch_mode),
        .reg_one_output_float(reg_one_output_float), .reg_one_enable(reg_one_enable),
        .reg_two_enable(reg_two_enable), .reg_one_target_mv(reg_one_target_mv),
        .reg_two_target_mv(reg_two_target_mv), .reg_two_switch_out(reg_two_switch_out),
        .reg_one_discharge(reg_one_discharge), .reg_two_discharge(reg_two_discharge),
        .system_shutdown(system_shutdown), .irq(irq));

    // expected millivolts of a five-bit voltage code
    function automatic logic [11:0] mv(input logic [4:0] c);
        if (c[4]) begin
            return 12'(1800 + 100 * int'(c[3:0]));
        end
        return 12'(900 + 50 * int'(c));
    endfunction : mv

    // verdict and end of run
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_of_test

    task automatic idle(input int n);
        repeat (n) @(posedge core_clk);
    endtask : idle

    // one-cycle write strobe
    task automatic write_reg(input logic [7:0] a, input logic [15:0] d);
        @(posedge core_clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge core_clk);
        wr    <= 1'b0;
    endtask : write_reg

    // one-cycle read strobe, data taken in the following cycle
    task automatic read_reg(input logic [7:0] a, output logic [15:0] d);
        @(posedge core_clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge core_clk);
        rd   <= 1'b0;
        #1 d = rdata;
    endtask : read_reg

    // cycles until each enable reaches lvl
    task automatic measure_edges(input logic lvl, output int c1, output int c2);
        c1 = -1;
        c2 = -1;
        for (int i = 0; i < 300 && (c1 < 0 || c2 < 0); i++) begin
            @(posedge core_clk);
            #1;
            if (c1 < 0 && reg_one_enable === lvl) c1 = i;
            if (c2 < 0 && reg_two_enable === lvl) c2 = i;
        end
        if (c1 < 0 || c2 < 0) begin
            miscompares++;
            $display("[ERR] %0t enable edge missing", $time);
            end_of_test();
        end
    endtask : measure_edges

    // poll the sequencer state field until it holds st
    task automatic wait_state(input logic [2:0] st);
        logic [15:0] s;
        for (int i = 0; i < 100; i++) begin
            read_reg(ADDR_SEQ_STATUS, s);
            if (s[6:4] === st) return;
        end
        miscompares++;
        $display("[ERR] %0t state wait ran out", $time);
        end_of_test();
    endtask : wait_state

    // fault pin pulse, watching for a system shutdown pulse
    task automatic fault_pulse(input bit two, output logic seen);
        seen = 1'b0;
        @(posedge core_clk);
        if (two) fault_two <= 1'b1; else fault_one <= 1'b1;
        for (int i = 0; i < 12; i++) begin
            @(posedge core_clk);
            if (i == 3) begin
                fault_one <= 1'b0;
                fault_two <= 1'b0;
            end
            #1 seen = seen | (system_shutdown === 1'b1);
        end
    endtask : fault_pulse

    initial begin
        idle(3);
        rst <= 1'b0;
        // defaults and register access
        read_reg(ADDR_ONE_SEQ, rv);
        `CHK(rv, 16'h0C00)
        read_reg(ADDR_ONE_LP, rv);
        `CHK(rv, 16'h001C)
        read_reg(ADDR_TWO_CTRL, rv);
        `CHK(rv, 16'h001B)
        read_reg(ADDR_TWO_SEQ, rv);
        `CHK(rv, 16'h0800)
        read_reg(8'h00, rv);
        `CHK(rv, 16'h0000)
        write_reg(ADDR_ONE_SEQ, 16'hFFFF);
        write_reg(ADDR_ONE_LP, 16'hDFFF);
        write_reg(ADDR_TWO_CTRL, 16'hFFFF);
        write_reg(ADDR_TWO_SEQ, 16'hFFFF);
        read_reg(ADDR_ONE_LP, rv);
        `CHK(rv, MASK_LP & 16'hDFFF)
        read_reg(ADDR_TWO_SEQ, rv);
        `CHK(rv, MASK_SEQ)
        @(posedge core_clk) sm_reset <= 1'b1;
        @(posedge core_clk) sm_reset <= 1'b0;
        read_reg(ADDR_ONE_LP, rv);
        `CHK(rv, 16'h001C)
        read_reg(ADDR_TWO_CTRL, rv);
        `CHK(rv, 16'h001B)
        $display("test registers done");
        // voltage decode, boundary codes and switch mode
        foreach (codes[k]) begin
            write_reg(ADDR_TWO_CTRL, {11'h000, codes[k]});
            idle(3);
            `CHK(reg_two_target_mv, mv(codes[k]))
        end
        write_reg(ADDR_TWO_CTRL, 16'h4010);
        idle(3);
        `CHK(reg_two_switch_out, 1'b1)
        `CHK(reg_two_target_mv, 12'h000)
        write_reg(ADDR_TWO_CTRL, 16'h0410);
        $display("test voltage done");
        // power-up: one in slot 3, two on entering active
        write_reg(ADDR_ONE_SEQ, 16'h0C80);
        write_reg(ADDR_TWO_SEQ, 16'h3C00);
        write_reg(ADDR_SEQ_CMD, 16'h0001);
        measure_edges(1'b1, t1, t2);
        `CHK(t2 - t1, 14 * SLOT_SIM - 3 * SLOT_SIM)
        wait_state(3'h2);
        idle(2);
        `CHK(reg_one_target_mv, mv(5'h05))
        // hibernate from register bit, then from low-power inputs one and two
        sleep_reg_bit <= 1'b1;
        idle(4);
        `CHK(reg_one_target_mv, mv(5'h1C))
        write_reg(ADDR_ONE_LP, 16'h101C);
        idle(3);
        `CHK(reg_one_enable, 1'b0)
        write_reg(ADDR_ONE_LP, 16'h011C);
        idle(3);
        `CHK(reg_one_target_mv, mv(5'h05))
        low_power_input_one <= 1'b1;
        idle(6);
        `CHK(reg_one_target_mv, mv(5'h1C))
        write_reg(ADDR_ONE_LP, 16'h021C);
        idle(3);
        `CHK(reg_one_target_mv, mv(5'h05))
        low_power_input_two <= 1'b1;
        idle(6);
        `CHK(reg_one_target_mv, mv(5'h1C))
        write_reg(ADDR_ONE_LP, 16'h031C);
        idle(3);
        `CHK(reg_one_target_mv, mv(5'h05))
        low_power_input_two <= 1'b0;
        low_power_input_one <= 1'b0;
        sleep_reg_bit       <= 1'b0;
        write_reg(ADDR_ONE_LP, 16'h001C);
        idle(6);
        `CHK(reg_one_enable, 1'b1)
        reg_one_switch_mode <= 1'b1;
        idle(3);
        `CHK(reg_one_target_mv, 12'h000)
        reg_one_switch_mode <= 1'b0;
        $display("test power-up and hibernate done");
        // power-down: one in slot 2, two on entering off
        write_reg(ADDR_SEQ_CMD, 16'h0002);
        measure_edges(1'b0, t1, t2);
        `CHK(t2 - t1, 14 * SLOT_SIM - 2 * SLOT_SIM)
        wait_state(3'h0);
        idle(2);
        `CHK(reg_one_discharge, 1'b1)
        `CHK(reg_two_discharge, 1'b0)
        others_disabled <= 1'b1;
        idle(3);
        `CHK(reg_two_discharge, 1'b1)
        others_disabled <= 1'b0;
        $display("test power-down done");
        // second power-up: one never starts, two in slot 1
        write_reg(ADDR_ONE_SEQ, 16'h0000);
        write_reg(ADDR_TWO_SEQ, 16'h0400);
        write_reg(ADDR_SEQ_CMD, 16'h0001);
        wait_state(3'h2);
        idle(2);
        `CHK(reg_one_enable, 1'b0)
        `CHK(reg_two_enable, 1'b1)
        // faults: interrupt, actions 00, 01, 10, 11
        write_reg(ADDR_IRQ_ENABLE, 16'h0003);
        fault_pulse(1'b1, saw);
        `CHK(irq, 1'b1)
        `CHK(saw, 1'b0)
        `CHK(reg_two_enable, 1'b1)
        read_reg(ADDR_IRQ_STATUS, rv);
        `CHK(rv[1:0], 2'b10)
        write_reg(ADDR_IRQ_CLEAR, 16'h0003);
        idle(1);
        `CHK(irq, 1'b0)
        write_reg(ADDR_TWO_SEQ, 16'h4400);
        fault_pulse(1'b1, saw);
        `CHK(reg_two_enable, 1'b0)
        `CHK(saw, 1'b0)
        write_reg(ADDR_IRQ_ENABLE, 16'h0000);
        write_reg(ADDR_ONE_SEQ, 16'h8000);
        fault_pulse(1'b0, saw);
        `CHK(saw, 1'b1)
        `CHK(irq, 1'b0)
        read_reg(ADDR_IRQ_STATUS, rv);
        `CHK(rv[1:0], 2'b11)
        write_reg(ADDR_ONE_SEQ, 16'hC000);
        fault_pulse(1'b0, saw);
        `CHK(saw, 1'b1)
        $display("test faults done");
        end_of_test();
    end
endmodule : rsc_regulators_bench
